// *** design/rcw_axil.sv ***
// axi4-lite slave front end for the sequencer registers
module rcw_axil (
	input wire logic ref_clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic [rcw_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [rcw_pkg::ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	rcw_reg_if.bus rif // register side
);
	import rcw_pkg::*;
	logic aw_held_r, w_held_r, strb0_r;
	logic [7:0] awaddr_r, wdata_r;
	logic both;

	assign both = aw_held_r && w_held_r;
	// only lane 0 carries a register; other lanes are accepted and dropped
	assign rif.wr_en = both && strb0_r;
	assign rif.wr_addr = awaddr_r;
	assign rif.wr_data = wdata_r;
	assign rif.rd_addr = s_axi_araddr;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 8'h00;
			strb0_r <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_r <= s_axi_awaddr;
				aw_held_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r <= s_axi_wdata[7:0];
				strb0_r <= s_axi_wstrb[0];
				w_held_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (both) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= rif.wr_err ? RESP_SLVERR : RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rif.rd_data};
			s_axi_rresp <= rif.rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// *** design/rcw_pkg.sv ***
// constants, register map and state types for the rc-watchdog sleep and reset sequencer
package rcw_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h00;
	localparam logic [7:0] OFS_INT_ENABLE_HIGH = 8'h04;
	localparam logic [7:0] OFS_PROGRAM_STATUS = 8'h08;
	localparam logic [7:0] OFS_WDT_COMPARE = 8'h0c;
	localparam logic [7:0] OFS_PORT_DATA = 8'h10;
	localparam logic [7:0] OFS_PORT_DIR = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_BIT_COUNT = 8'h1c;
	localparam logic [3:0] RAM_PAGE = 4'h2;
	localparam int CKC_WAKE_BIT = 6;
	localparam int CKC_RC_BIT = 5;
	localparam int CKC_WATCHDOG_RESET_SELECT_BIT = 4;
	localparam int CKC_PRE_MSB = 2;
	localparam int IEH_WATCHDOG_INTERRUPT_ENABLE_BIT = 0;
	localparam int PSW_IFLAG_BIT = 2;
	localparam logic [7:0] CKC_RST = 8'h00;
	localparam logic [7:0] IEH_RST = 8'h00;
	localparam logic [7:0] PSW_RST = 8'h00;
	localparam logic [7:0] WDT_CMP_RST = 8'hff;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [7:0] BIT_TOP = 8'hff;
	localparam logic [23:0] BIT_PRE_BASE = 24'h000010;
	localparam int CLK_PERIOD_NS = 5;
	localparam int CLK_PER_MS = 200000;
	localparam int STARTUP_MS = 64;
	localparam int OSC_PERIOD_NS = 250;
	localparam int STARTUP_OSC_PERIODS = 7;
	localparam int STARTUP_EXTRA_CYC = (STARTUP_OSC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned START_CYC_DEF = STARTUP_MS * CLK_PER_MS + STARTUP_EXTRA_CYC;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_START = 3'b001,
		ST_RUN = 3'b010,
		ST_SLEEP = 3'b011,
		ST_STAB = 3'b100
	} rcw_state_t;
	typedef enum logic [1:0] {
		MD_STOP = 2'b00,
		MD_RC = 2'b01,
		MD_WAKE = 2'b10
	} rcw_mode_t;
endpackage

// *** design/rcw_reg_if.sv ***
// register access carrier between the bus slave and the sequencer
interface rcw_reg_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_err;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic rd_err;
	modport bus (output wr_en, output wr_addr, output wr_data, output rd_addr,
		input wr_err, input rd_data, input rd_err);
	modport regs (input wr_en, input wr_addr, input wr_data, input rd_addr,
		output wr_err, output rd_data, output rd_err);
endinterface

// *** design/rcw_seq.sv ***
// low-power mode, wake-up stabilisation and reset sequencer with its registers
// Summary of operation
// RULE1: stop with select pattern 01 enters rc-watchdog sleep.
// RULE2: rc sleep halts main oscillator, keeps rc oscillator, keeps registers and ram.
// RULE3: port pins keep driving their data and direction values during sleep.
// RULE4: firmware writes the clock control register as a whole byte.
// RULE5: firmware follows the stop with at least two no-operations.
// RULE6: rc sleep ends on hardware reset or external interrupt.
// RULE7: reset release reinitialises control registers; interrupt release keeps everything.
// RULE8: interrupt flag set: normal response; watchdog vector if reset select 0, enable 1.
// RULE9: interrupt flag set with watchdog reset select 1: internal reset and full reset.
// RULE10: interrupt flag clear: continue after stop, no vectoring.
// RULE11: interrupt wake counts interval timer 00 to ff, resumes on overflow.
// RULE12: firmware picks a prescaler giving over 20 ms of stabilisation.
// RULE13: external reset low holds at least 8 oscillator periods.
// RULE14: after reset release wait 64 ms at 4 MHz plus 7 periods.
// RULE15: no reset touches ram; ram is undefined after power-up.
// RULE16: power-on enable set: supply rise makes an internal reset pulse.
// RULE17: startup count begins only after the reset pin returns high.
// RULE18: a falling supply makes no internal reset.
// RULE19: stop with 00 gives full stop; wake-timer select 1 gives timer mode.
// RULE20: the global interrupt flag is bit 2 of the status word.
// RULE21: watchdog counts rc ticks in rc sleep; timeout is a wake source.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
module rcw_seq #(
	parameter int unsigned START_CYC = rcw_pkg::START_CYC_DEF
) (
	input wire logic ref_clk, // 200 MHz clock
	input wire logic rst, // async reset, high
	input wire logic [rcw_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [rcw_pkg::ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic reset_n_pin, // external reset, low
	input wire logic por_enable_cfg, // power-on reset enable strap
	input wire logic vdd_rise, // supply rise detected, pulse
	input wire logic stop_exec, // stop instruction executed, pulse
	input wire logic ext_irq, // external interrupt request
	input wire logic timer0_ovf, // timer0 overflow, pulse
	input wire logic rc_tick, // rc oscillator tick, pulse
	output logic main_osc_en, // main oscillator enable
	output logic rc_osc_en, // rc oscillator enable
	output logic cpu_run, // core may execute
	output logic int_reset, // internal core reset
	output logic irq_take, // normal interrupt response, pulse
	output logic wdt_vector, // watchdog handler vector, pulse
	output logic resume_next, // continue after stop, pulse
	output logic [7:0] port_out, // port data drive
	output logic [7:0] port_dir // port direction, 1 drives
);
	import rcw_pkg::*;

	rcw_reg_if rif();

	rcw_axil u_axil (
		.ref_clk(ref_clk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rif(rif.bus)
	);

	rcw_state_t state_r, state_nxt;
	rcw_mode_t mode_r, mode_sel, mode_eff;
	logic [7:0] ckctl_r, interrupt_enable_high_register_r, psw_r, wdtcmp_r, port_data_r, port_dir_r;
	logic [7:0] ram_r [4];
	logic [23:0] start_cnt_r, pre_r, div_mask;
	logic [7:0] bit_r, wdt_cnt_r;
	logic wdt_src_r, src_wdt;
	logic main_osc_r, rc_osc_r, cpu_run_r, int_reset_r;
	logic irq_take_r, wdt_vec_r, resume_r;
	logic iflag, watchdog_reset_select, watchdog_interrupt_enable, por_req, reset_req;
	logic wdt_hit, wake, bit_tick, bit_ovf;
	logic rel_now, rel_reset, take_vec;
	logic ram_hit_w, ram_hit_r;

	assign iflag = psw_r[PSW_IFLAG_BIT]; // RULE20
	assign watchdog_reset_select = ckctl_r[CKC_WATCHDOG_RESET_SELECT_BIT];
	assign watchdog_interrupt_enable = interrupt_enable_high_register_r[IEH_WATCHDOG_INTERRUPT_ENABLE_BIT];
	// supply fall has no input here, so it can never reset the core
	assign por_req = vdd_rise && por_enable_cfg; // RULE16 RULE18
	// pin is trusted to be held long enough by the external circuit
	assign reset_req = !reset_n_pin || por_req; // RULE13

	always_comb begin
		mode_sel = MD_STOP; // RULE19
		if (ckctl_r[CKC_WAKE_BIT]) begin
			mode_sel = MD_WAKE; // RULE19
		end else if (ckctl_r[CKC_RC_BIT]) begin
			mode_sel = MD_RC; // RULE1
		end
	end
	assign mode_eff = (state_r == ST_RUN) ? mode_sel : mode_r;

	// watchdog runs from rc ticks only; main clock is off in this mode
	assign wdt_hit = (state_r == ST_SLEEP) && (mode_r == MD_RC) && rc_tick && (wdt_cnt_r == wdtcmp_r); // RULE21
	assign wake = ext_irq || wdt_hit || ((mode_r == MD_WAKE) && timer0_ovf); // RULE6
	assign src_wdt = (state_r == ST_STAB) ? wdt_src_r : 1'b0;

	// prescaler divides by 16 up to 16*4^7 so 256 ticks can exceed 20 ms
	assign div_mask = (BIT_PRE_BASE << {ckctl_r[CKC_PRE_MSB:0], 1'b0}) - 24'h000001; // RULE12
	assign bit_tick = (pre_r & div_mask) == div_mask;
	assign bit_ovf = bit_tick && (bit_r == BIT_TOP); // RULE11

	// stabilised wake, or timer-mode wake where the oscillator never stopped
	assign rel_now = !reset_req && (((state_r == ST_STAB) && bit_ovf)
		|| ((state_r == ST_SLEEP) && (mode_r == MD_WAKE) && wake));
	assign rel_reset = rel_now && iflag && src_wdt && watchdog_reset_select; // RULE9
	assign take_vec = iflag && (!src_wdt || watchdog_interrupt_enable) && !(src_wdt && watchdog_reset_select); // RULE8

	always_comb begin
		state_nxt = state_r;
		if (reset_req) begin
			state_nxt = ST_RESET;
		end else begin
			unique case (state_r)
				ST_RESET: state_nxt = ST_START; // RULE17
				ST_START: begin
					if (start_cnt_r == 24'(START_CYC - 1)) begin
						state_nxt = ST_RUN; // RULE14
					end
				end
				ST_RUN: begin
					if (stop_exec) begin
						state_nxt = ST_SLEEP; // RULE1
					end
				end
				ST_SLEEP: begin
					if (wake) begin
						state_nxt = (mode_r == MD_WAKE) ? ST_RUN : ST_STAB; // RULE6 RULE19
					end
				end
				ST_STAB: begin
					if (bit_ovf) begin
						state_nxt = rel_reset ? ST_RESET : ST_RUN; // RULE9 RULE11
					end
				end
				default: state_nxt = ST_RESET;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_r <= MD_STOP;
			wdt_src_r <= 1'b0;
		end else begin
			if (state_r == ST_RUN && state_nxt == ST_SLEEP) begin
				mode_r <= mode_sel; // RULE19
			end
			if (state_r == ST_SLEEP && state_nxt == ST_STAB) begin
				wdt_src_r <= !ext_irq; // external request wins a tie
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			start_cnt_r <= 24'h000000;
		end else if (state_r == ST_START && state_nxt == ST_START) begin
			start_cnt_r <= start_cnt_r + 24'h000001; // RULE14
		end else begin
			start_cnt_r <= 24'h000000; // RULE17
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pre_r <= 24'h000000;
			bit_r <= 8'h00;
		end else if (state_r == ST_STAB) begin
			pre_r <= pre_r + 24'h000001;
			if (bit_tick) begin
				bit_r <= bit_r + 8'h01; // RULE11
			end
		end else begin
			pre_r <= 24'h000000;
			bit_r <= 8'h00; // RULE11
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wdt_cnt_r <= 8'h00;
		end else if (state_r != ST_SLEEP) begin
			wdt_cnt_r <= 8'h00;
		end else if (mode_r == MD_RC && rc_tick) begin
			wdt_cnt_r <= wdt_hit ? 8'h00 : wdt_cnt_r + 8'h01; // RULE21
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			main_osc_r <= 1'b1;
			rc_osc_r <= 1'b0;
			cpu_run_r <= 1'b0;
			int_reset_r <= 1'b1;
		end else begin
			main_osc_r <= !(state_nxt == ST_SLEEP && mode_eff != MD_WAKE); // RULE2 RULE19
			rc_osc_r <= state_nxt == ST_SLEEP && mode_eff == MD_RC; // RULE2
			cpu_run_r <= state_nxt == ST_RUN;
			int_reset_r <= state_nxt == ST_RESET || state_nxt == ST_START; // RULE9 RULE14
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_take_r <= 1'b0;
			wdt_vec_r <= 1'b0;
			resume_r <= 1'b0;
		end else begin
			irq_take_r <= rel_now && take_vec && !src_wdt; // RULE8
			wdt_vec_r <= rel_now && take_vec && src_wdt; // RULE8
			resume_r <= rel_now && !rel_reset && !take_vec; // RULE10
		end
	end

	assign ram_hit_w = (rif.wr_addr[7:4] == RAM_PAGE) && (rif.wr_addr[1:0] == 2'b00);
	assign ram_hit_r = (rif.rd_addr[7:4] == RAM_PAGE) && (rif.rd_addr[1:0] == 2'b00);

	// control registers return to defaults under internal reset only
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ckctl_r <= CKC_RST;
			interrupt_enable_high_register_r <= IEH_RST;
			psw_r <= PSW_RST;
			wdtcmp_r <= WDT_CMP_RST;
			port_data_r <= PORT_RST;
			port_dir_r <= PORT_RST;
		end else if (int_reset_r) begin
			ckctl_r <= CKC_RST; // RULE7
			interrupt_enable_high_register_r <= IEH_RST;
			psw_r <= PSW_RST;
			wdtcmp_r <= WDT_CMP_RST;
			port_data_r <= PORT_RST;
			port_dir_r <= PORT_RST;
		end else if (rif.wr_en) begin
			unique case (rif.wr_addr)
				OFS_CLOCK_CONTROL: ckctl_r <= rif.wr_data;
				OFS_INT_ENABLE_HIGH: interrupt_enable_high_register_r <= rif.wr_data;
				OFS_PROGRAM_STATUS: psw_r <= rif.wr_data;
				OFS_WDT_COMPARE: wdtcmp_r <= rif.wr_data;
				OFS_PORT_DATA: port_data_r <= rif.wr_data;
				OFS_PORT_DIR: port_dir_r <= rif.wr_data;
				default: ;
			endcase
		end
	end

	// ram is never reset so its contents survive every reset
	always_ff @(posedge ref_clk) begin
		if (rif.wr_en && ram_hit_w) begin
			ram_r[rif.wr_addr[3:2]] <= rif.wr_data; // RULE15
		end
	end

	always_comb begin
		rif.rd_err = 1'b0;
		unique case (rif.rd_addr)
			OFS_CLOCK_CONTROL: rif.rd_data = ckctl_r;
			OFS_INT_ENABLE_HIGH: rif.rd_data = interrupt_enable_high_register_r;
			OFS_PROGRAM_STATUS: rif.rd_data = psw_r;
			OFS_WDT_COMPARE: rif.rd_data = wdtcmp_r;
			OFS_PORT_DATA: rif.rd_data = port_data_r;
			OFS_PORT_DIR: rif.rd_data = port_dir_r;
			OFS_STATUS: rif.rd_data = {2'b00, wdt_src_r, mode_r, state_r};
			OFS_BIT_COUNT: rif.rd_data = bit_r;
			default: begin
				rif.rd_data = ram_hit_r ? ram_r[rif.rd_addr[3:2]] : 8'h00;
				rif.rd_err = !ram_hit_r;
			end
		endcase
	end

	always_comb begin
		unique case (rif.wr_addr)
			OFS_CLOCK_CONTROL, OFS_INT_ENABLE_HIGH, OFS_PROGRAM_STATUS,
			OFS_WDT_COMPARE, OFS_PORT_DATA, OFS_PORT_DIR: rif.wr_err = 1'b0;
			default: rif.wr_err = !ram_hit_w;
		endcase
	end

	assign main_osc_en = main_osc_r;
	assign rc_osc_en = rc_osc_r;
	assign cpu_run = cpu_run_r;
	assign int_reset = int_reset_r;
	assign irq_take = irq_take_r;
	assign wdt_vector = wdt_vec_r;
	assign resume_next = resume_r;
	assign port_out = port_data_r; // RULE3
	assign port_dir = port_dir_r; // RULE3

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_stab_done;
		state_r == ST_STAB && bit_ovf && !reset_req;
	endsequence

	sequence s_rc_stop;
		state_r == ST_RUN && stop_exec && !reset_req && mode_sel == MD_RC;
	endsequence

	a_rc_entry: assert property (s_rc_stop |=> state_r == ST_SLEEP && mode_r == MD_RC && rc_osc_en) // RULE1
		else $error("rc sleep not entered");
	a_rc_clocks: assert property (state_r == ST_SLEEP && mode_r == MD_RC |-> !main_osc_en && rc_osc_en) // RULE2
		else $error("oscillator enables wrong in rc sleep");
	a_port_hold: assert property (state_r == ST_SLEEP && !rif.wr_en && !int_reset_r |=> $stable(port_out)) // RULE3
		else $error("port drive changed in sleep");
	a_ext_wake: assert property (state_r == ST_SLEEP && mode_r == MD_RC && ext_irq && !reset_req
		|=> state_r == ST_STAB && !wdt_src_r) // RULE6
		else $error("external wake missed");
	a_wake_keeps: assert property (state_r == ST_SLEEP && ext_irq && !reset_req && !rif.wr_en
		|=> $stable(ckctl_r) && $stable(psw_r)) // RULE7
		else $error("wake disturbed control registers");
	a_wdt_vector: assert property (s_stab_done ##0 (wdt_src_r && iflag && !watchdog_reset_select && watchdog_interrupt_enable)
		|=> wdt_vector && !irq_take && cpu_run) // RULE8
		else $error("watchdog vector not taken");
	a_wdt_reset: assert property (s_stab_done ##0 (wdt_src_r && iflag && watchdog_reset_select)
		|=> int_reset && !cpu_run ##1 state_r == ST_START) // RULE9
		else $error("watchdog reset not raised");
	a_plain_resume: assert property (s_stab_done ##0 !iflag |=> resume_next && !irq_take && !wdt_vector) // RULE10
		else $error("resume without vector failed");
	a_stab_start: assert property ($rose(state_r == ST_STAB) |-> bit_r == 8'h00 && main_osc_en) // RULE11
		else $error("stabilisation count not from zero");
	a_stab_hold: assert property (state_r == ST_STAB && !bit_ovf && !reset_req |=> state_r == ST_STAB) // RULE11
		else $error("left stabilisation before overflow");
	a_start_delay: assert property (state_r == ST_START && !reset_req && start_cnt_r != 24'(START_CYC - 1)
		|=> state_r == ST_START && !cpu_run) // RULE14
		else $error("startup delay cut short");
	a_pin_hold: assert property (!reset_n_pin |=> state_r == ST_RESET && int_reset) // RULE17
		else $error("startup began with pin low");
	a_por_pulse: assert property (vdd_rise && por_enable_cfg |=> int_reset ##1 (int_reset || state_r != ST_RUN)) // RULE16
		else $error("power-on reset missing");
endmodule

// *** sim/rcw_far.sv ***
// far-side model: reset circuit, external interrupt source and rc oscillator
module rcw_far (
	input wire logic ref_clk, // system clock
	input wire logic rc_osc_en, // rc oscillator enable from device
	input wire logic pin_go, // start one reset pin pulse
	input wire logic irq_go, // raise the external interrupt
	output logic reset_n_pin, // reset pin, low active
	output logic ext_irq, // external interrupt
	output logic rc_tick // rc oscillator tick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] low_r = 9'h000;
	logic [1:0] rc_r = 2'h0;
	// 8 periods of 50 cycles plus margin, never shorter
	always_ff @(posedge ref_clk) begin
		if (pin_go)
			low_r <= 9'h19a;
		else if (low_r != 9'h000)
			low_r <= low_r - 9'h001;
	end
	assign reset_n_pin = (low_r == 9'h000);
	always_ff @(posedge ref_clk)
		ext_irq <= irq_go;
	// rc clock stands still while disabled
	always_ff @(posedge ref_clk)
		rc_r <= rc_osc_en ? rc_r + 2'h1 : 2'h0;
	assign rc_tick = rc_osc_en && (rc_r == 2'h3);
endmodule

// *** sim/rcw_seq_tb.sv ***
// self-checking bench for the rc-watchdog sleep and reset sequencer
module rcw_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rcw_pkg::*;
	localparam int SC = 20;
	logic ref_clk = 0;
	logic rst = 1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic por_en = 0, vdd_rise = 0, stop_exec = 0, t0_ovf = 0, pin_go = 0, irq_go = 0;
	logic reset_n_pin, ext_irq, rc_tick, main_osc_en, rc_osc_en, cpu_run, int_reset;
	logic irq_take, wdt_vector, resume_next;
	logic [7:0] port_out, port_dir;
	int mismatches = 0, compares = 0, n;
	always #2.5 ref_clk = ~ref_clk;
	rcw_seq #(.START_CYC(SC)) i_dut (.ref_clk(ref_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.reset_n_pin(reset_n_pin), .por_enable_cfg(por_en), .vdd_rise(vdd_rise),
		.stop_exec(stop_exec), .ext_irq(ext_irq), .timer0_ovf(t0_ovf), .rc_tick(rc_tick),
		.main_osc_en(main_osc_en), .rc_osc_en(rc_osc_en), .cpu_run(cpu_run),
		.int_reset(int_reset), .irq_take(irq_take), .wdt_vector(wdt_vector),
		.resume_next(resume_next), .port_out(port_out), .port_dir(port_dir));
	rcw_far i_far (.ref_clk(ref_clk), .rc_osc_en(rc_osc_en), .pin_go(pin_go), .irq_go(irq_go),
		.reset_n_pin(reset_n_pin), .ext_irq(ext_irq), .rc_tick(rc_tick));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		// address and data may be taken on different edges
		fork
			begin do @(posedge ref_clk); while (!awready); awvalid <= 0; end
			begin do @(posedge ref_clk); while (!wready); wvalid <= 0; end
		join
		do @(posedge ref_clk); while (!bvalid);
		bready <= 0;
		chk("bresp", bresp, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge ref_clk); while (!arready);
		arvalid <= 0;
		do @(posedge ref_clk); while (!rvalid);
		rready <= 0;
		chk("rdata", rdata, ed);
		chk("rresp", rresp, er);
	endtask
	// k: 0 supply rise, 1 reset pin, 2 timer0, 3 interrupt, 4 stop
	task automatic pulse(input int k);
		@(posedge ref_clk);
		{stop_exec, irq_go, t0_ovf, pin_go, vdd_rise} <= 5'h01 << k;
		@(posedge ref_clk);
		{stop_exec, irq_go, t0_ovf, pin_go, vdd_rise} <= 5'h00;
	endtask
	// settled look after each edge; bounded so a hang cannot stall here
	task automatic wait_hi(input bit on_rst);
		n = 0;
		do begin @(posedge ref_clk); #1; n++; end
		while (((on_rst ? int_reset : cpu_run) !== 1'b1) && n < 30000);
		chk("wait_hi", 32'(n < 30000), 1);
	endtask
	task automatic nap(input logic [7:0] ckc, input logic [7:0] program_status_word, input logic [7:0] ieh);
		// prescaler 0 keeps runs short; real firmware needs a ratio giving over 20 ms
		wr(OFS_CLOCK_CONTROL, ckc, RESP_OKAY);
		wr(OFS_PROGRAM_STATUS, program_status_word, RESP_OKAY);
		wr(OFS_INT_ENABLE_HIGH, ieh, RESP_OKAY);
		pulse(4);
		// idle cycles stand in for the no-operations after stop
		repeat (2) @(posedge ref_clk);
		#1;
	endtask
	task automatic s_boot;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("run_early", cpu_run, 0);
		wait_hi(0);
		chk("start_len", 32'(n >= SC - 3 && n <= SC + 3), 1);
		rd(OFS_CLOCK_CONTROL, 0, RESP_OKAY);
		rd(OFS_WDT_COMPARE, 32'hff, RESP_OKAY);
		rd(8'h40, 0, RESP_SLVERR);
		wr(8'h40, 32'h5a, RESP_SLVERR);
		wr(OFS_STATUS, 32'h5a, RESP_SLVERR);
	endtask
	task automatic s_rc_ext;
		wr(OFS_PORT_DATA, 32'ha5, RESP_OKAY);
		wr(OFS_PORT_DIR, 32'h3c, RESP_OKAY);
		wr(8'h20, 32'h5a, RESP_OKAY);
		nap(8'h20, 8'h00, 8'h00);
		chk("osc_off", {main_osc_en, rc_osc_en, cpu_run}, 3'b010);
		chk("ports", {port_out, port_dir}, 16'ha53c);
		rd(OFS_STATUS, {2'b00, 1'b0, MD_RC, ST_SLEEP}, RESP_OKAY);
		pulse(3);
		wait_hi(0);
		chk("stab_len", 32'(n >= 4096 && n <= 4110), 1);
		chk("resume", {resume_next, irq_take, main_osc_en}, 3'b101);
		rd(OFS_CLOCK_CONTROL, 32'h20, RESP_OKAY);
	endtask
	task automatic s_rc_wake(input logic [7:0] ckc, input logic [7:0] ieh, input int src);
		nap(ckc, 8'h04, ieh);
		if (src == 3)
			pulse(3);
		wait_hi(ckc[4]);
	endtask
	task automatic s_wake_sources;
		s_rc_wake(8'h20, 8'h00, 3);
		chk("irq", {irq_take, wdt_vector, resume_next}, 3'b100);
		wr(OFS_WDT_COMPARE, 32'h03, RESP_OKAY);
		s_rc_wake(8'h20, 8'h01, 0);
		chk("wdt", {irq_take, wdt_vector, resume_next}, 3'b010);
		s_rc_wake(8'h30, 8'h00, 0);
		chk("wdt_rst", {int_reset, cpu_run}, 2'b10);
		wait_hi(0);
		rd(OFS_CLOCK_CONTROL, 0, RESP_OKAY);
		rd(8'h20, 32'h5a, RESP_OKAY);
	endtask
	task automatic s_other_modes;
		nap(8'h00, 8'h00, 8'h00);
		chk("full_stop", {main_osc_en, rc_osc_en}, 2'b00);
		pulse(3);
		wait_hi(0);
		nap(8'h40, 8'h00, 8'h00);
		chk("timer_mode", {main_osc_en, cpu_run}, 2'b10);
		pulse(2);
		wait_hi(0);
		chk("timer_fast", 32'(n <= 4), 1);
	endtask
	task automatic s_resets;
		pulse(1);
		wait_hi(1);
		wait_hi(0);
		chk("pin_hold", 32'(n >= 400 + SC), 1);
		pulse(0);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("no_por", int_reset, 0);
		@(posedge ref_clk);
		por_en <= 1;
		pulse(0);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("por", int_reset, 1);
		wait_hi(0);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 0;
		s_boot();
		s_rc_ext();
		s_wake_sources();
		s_other_modes();
		s_resets();
		tally_and_finish();
	end
	initial begin
		#400us;
		mismatches++;
		tally_and_finish();
	end
endmodule
